// ---- design/bit_pkg.sv ----
`default_nettype none
package bit_pkg;
    // ==========================================================
    // widths and divider defaults
    localparam int CNT_W = 7;
    localparam int WD_W = 8;
    localparam int PRE_W = 13;
    localparam int DIV_SLOW_DEF = 8192;
    localparam int DIV_FAST_DEF = 4096;

    // ==========================================================
    // register word indices, byte address is four times the index
    localparam logic [4:0] IDX_MODE = 5'h13;
    localparam logic [4:0] IDX_WDOG = 5'h14;
    localparam logic [4:0] IDX_COUNT = 5'h15;
    localparam logic [4:0] IDX_STAT = 5'h16;
    localparam logic [4:0] IDX_MASK = 5'h17;

    // ==========================================================
    // field positions
    localparam int MODE_ISEL = 3;
    localparam int MODE_CLR = 2;
    localparam int MODE_SRC_HI = 1;
    localparam int MODE_SRC_LO = 0;
    localparam int WDOG_RESTART = 0;
    localparam int WDOG_ARM = 1;
    localparam int WDOG_ZC = 2;
    localparam int EV_INTERVAL = 0;
    localparam int EV_WAIT = 1;
    localparam int EV_WDOG = 2;
    localparam int EV_W = 3;

    // ==========================================================
    // encodings and limits
    localparam logic [1:0] SRC_DIV8192 = 2'h0;
    localparam logic [1:0] SRC_DIV4096 = 2'h1;
    localparam logic [1:0] SRC_TMR0 = 2'h2;
    localparam logic [1:0] SRC_PIN = 2'h3;
    localparam logic [6:0] CNT_ONE = 7'h01;
    localparam logic [6:0] CNT_LAST_128 = 7'h7F;
    localparam logic [4:0] CNT_LAST_32 = 5'h1F;
    localparam logic [7:0] WD_ONE = 8'h01;
    localparam logic [7:0] WD_OPEN = 8'h08;
    localparam logic [7:0] WD_FIRE = 8'hC0;
    localparam logic [2:0] EV_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic fast;
        logic slow;
    } tick_s;

    typedef struct packed {
        logic [PRE_W-1:0] cnt;
        tick_s tick;
    } pre_state_s;

    typedef struct packed {
        logic [6:0] counter;
        logic isel;
        logic [1:0] src;
        logic wd_arm;
        logic zc_en;
        logic [7:0] wd_cnt;
        logic wait_busy;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic zc_s1;
        logic zc_s2;
        logic zc_s3;
        logic dp_write;
        logic [4:0] dp_idx;
        logic [31:0] hrdata;
        logic hreadyout;
        logic interval_evt;
        logic wait_done;
        logic wdt_reset;
        logic irq;
    } timer_state_s;
endpackage : bit_pkg
`default_nettype wire

// ---- design/bit_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module bit_prescaler #(
    parameter int DIV_SLOW = bit_pkg::DIV_SLOW_DEF,
    parameter int DIV_FAST = bit_pkg::DIV_FAST_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // divided clock enables
    output bit_pkg::tick_s o_tick
);
    import bit_pkg::*;

    localparam logic [PRE_W-1:0] LAST_SLOW = PRE_W'(DIV_SLOW - 1);
    localparam logic [PRE_W-1:0] LAST_FAST = PRE_W'(DIV_FAST - 1);
    localparam logic [PRE_W-1:0] PRE_ONE = PRE_W'(1);

    pre_state_s st_ff;
    pre_state_s nxt_st;

    // ==========================================================
    // one counter, fast tick twice per slow period
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick.slow = (st_ff.cnt == LAST_SLOW);
        nxt_st.tick.fast = (st_ff.cnt == LAST_SLOW) || (st_ff.cnt == LAST_FAST);
        if (st_ff.cnt == LAST_SLOW) begin
            nxt_st.cnt = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + PRE_ONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_tick = st_ff.tick;
endmodule : bit_prescaler
`default_nettype wire

// ---- design/basic_interval_timer.sv ----
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module basic_interval_timer #(
    parameter int DIV_SLOW = bit_pkg::DIV_SLOW_DEF,
    parameter int DIV_FAST = bit_pkg::DIV_FAST_DEF
) (
    // clock and reset
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // count sources
    input wire logic I_TMR0_COUNTUP,
    input wire logic I_EVENT_PIN,
    input wire logic I_ZERO_CROSS,
    // standby
    input wire logic I_STANDBY_RELEASE,
    // events
    output logic O_INTERVAL_EVT,
    output logic O_WAIT_DONE,
    output logic O_WDT_RESET,
    output logic O_IRQ
);
    import bit_pkg::*;

    timer_state_s st_ff;
    timer_state_s nxt_st;
    tick_s tick;
    logic pulse;
    logic pin_edge;
    logic zc_edge;
    logic clr_req;
    logic restart_req;
    logic interval_hit;
    logic wd_fire;
    logic addr_ok;
    logic addr_phase;
    logic wr_mode;
    logic wr_wdog;
    logic [31:0] rd_mux;
    logic [2:0] ev_set;

    // ==========================================================
    // divided system clock enables
    bit_prescaler #(
        .DIV_SLOW(DIV_SLOW),
        .DIV_FAST(DIV_FAST)
    ) u_prescaler (
        .i_clk(I_CLK_SYS),
        .i_rst(I_RST),
        .o_tick(tick)
    );

    // ==========================================================
    // bus decode
    always_comb begin
        addr_ok = (I_HADDR[31:7] == '0) && (I_HADDR[1:0] == 2'h0);
        addr_phase = I_HSEL && I_HREADY && I_HTRANS[1];
        wr_mode = st_ff.dp_write && (st_ff.dp_idx == IDX_MODE);
        wr_wdog = st_ff.dp_write && (st_ff.dp_idx == IDX_WDOG);
        clr_req = wr_mode && I_HWDATA[MODE_CLR];
        restart_req = wr_wdog && I_HWDATA[WDOG_RESTART];
        rd_mux = RDATA_RST;
        if (addr_ok) begin
            unique case (I_HADDR[6:2])
                IDX_MODE: begin
                    // clear bit never stored, so it reads zero
                    rd_mux[MODE_ISEL] = st_ff.isel;
                    rd_mux[MODE_SRC_HI] = st_ff.src[1];
                    rd_mux[MODE_SRC_LO] = st_ff.src[0];
                end
                IDX_WDOG: begin
                    rd_mux[WDOG_ARM] = st_ff.wd_arm;
                    rd_mux[WDOG_ZC] = st_ff.zc_en;
                end
                IDX_COUNT: rd_mux[6:0] = st_ff.counter;
                IDX_STAT: rd_mux[2:0] = st_ff.irq_stat;
                IDX_MASK: rd_mux[2:0] = st_ff.irq_mask;
                default: rd_mux = RDATA_RST;
            endcase
        end
    end

    // ==========================================================
    // count pulse selection
    always_comb begin
        pin_edge = st_ff.pin_s2 && !st_ff.pin_s3;
        zc_edge = st_ff.zc_s2 && !st_ff.zc_s3;
        unique case (st_ff.src)
            SRC_DIV8192: pulse = tick.slow;
            SRC_DIV4096: pulse = tick.fast;
            SRC_TMR0: pulse = I_TMR0_COUNTUP;
            SRC_PIN: pulse = st_ff.zc_en ? zc_edge : pin_edge;
        endcase
        if (st_ff.isel) begin
            interval_hit = pulse && (st_ff.counter[4:0] == CNT_LAST_32);
        end else begin
            interval_hit = pulse && (st_ff.counter == CNT_LAST_128);
        end
        interval_hit = interval_hit && !clr_req;
        wd_fire = st_ff.wd_arm && ((restart_req && (st_ff.wd_cnt < WD_OPEN))
                  || (!restart_req && !clr_req && pulse
                  && ((st_ff.wd_cnt + WD_ONE) == WD_FIRE)));
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.pin_s1 = I_EVENT_PIN;
        nxt_st.pin_s2 = st_ff.pin_s1;
        nxt_st.pin_s3 = st_ff.pin_s2;
        nxt_st.zc_s1 = I_ZERO_CROSS;
        nxt_st.zc_s2 = st_ff.zc_s1;
        nxt_st.zc_s3 = st_ff.zc_s2;
        // base counter, clear wins over a count
        if (clr_req) begin
            nxt_st.counter = '0;
        end else if (pulse) begin
            nxt_st.counter = st_ff.counter + CNT_ONE;
        end
        // mode writes touch the counter only through the clear bit
        if (wr_mode) begin
            nxt_st.isel = I_HWDATA[MODE_ISEL];
            nxt_st.src = {I_HWDATA[MODE_SRC_HI], I_HWDATA[MODE_SRC_LO]};
        end
        if (wr_wdog) begin
            nxt_st.wd_arm = st_ff.wd_arm || I_HWDATA[WDOG_ARM];
            nxt_st.zc_en = I_HWDATA[WDOG_ZC];
        end
        // watchdog count, restart or counter clear rearms it
        if (restart_req || clr_req || wd_fire) begin
            nxt_st.wd_cnt = '0;
        end else if (st_ff.wd_arm && pulse) begin
            nxt_st.wd_cnt = st_ff.wd_cnt + WD_ONE;
        end
        nxt_st.wdt_reset = wd_fire;
        nxt_st.interval_evt = interval_hit;
        // standby wait ends at the next completed interval
        nxt_st.wait_done = st_ff.wait_busy && interval_hit;
        if (I_STANDBY_RELEASE) begin
            nxt_st.wait_busy = 1'b1;
        end else if (interval_hit) begin
            nxt_st.wait_busy = 1'b0;
        end
        // sticky status, set wins over write-one clear
        ev_set = '0;
        ev_set[EV_INTERVAL] = interval_hit;
        ev_set[EV_WAIT] = st_ff.wait_busy && interval_hit;
        ev_set[EV_WDOG] = wd_fire;
        if (st_ff.dp_write && (st_ff.dp_idx == IDX_STAT)) begin
            nxt_st.irq_stat = (st_ff.irq_stat & ~I_HWDATA[2:0]) | ev_set;
        end else begin
            nxt_st.irq_stat = st_ff.irq_stat | ev_set;
        end
        if (st_ff.dp_write && (st_ff.dp_idx == IDX_MASK)) begin
            nxt_st.irq_mask = I_HWDATA[2:0];
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
        // bus pipeline, zero wait states
        nxt_st.dp_write = addr_phase && I_HWRITE && addr_ok;
        nxt_st.dp_idx = I_HADDR[6:2];
        nxt_st.hreadyout = 1'b1;
        if (addr_phase && !I_HWRITE) begin
            nxt_st.hrdata = rd_mux;
        end else begin
            nxt_st.hrdata = RDATA_RST;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            st_ff <= '0;
            st_ff.hreadyout <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign O_HRDATA = st_ff.hrdata;
    assign O_HREADYOUT = st_ff.hreadyout;
    assign O_HRESP = 1'b0;
    assign O_INTERVAL_EVT = st_ff.interval_evt;
    assign O_WAIT_DONE = st_ff.wait_done;
    assign O_WDT_RESET = st_ff.wdt_reset;
    assign O_IRQ = st_ff.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);

    logic rd_mode_q;
    logic rd_wdog_q;
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            rd_mode_q <= 1'b0;
            rd_wdog_q <= 1'b0;
        end else begin
            rd_mode_q <= addr_phase && !I_HWRITE && addr_ok && (I_HADDR[6:2] == IDX_MODE);
            rd_wdog_q <= addr_phase && !I_HWRITE && addr_ok && (I_HADDR[6:2] == IDX_WDOG);
        end
    end

    sequence s_release;
        I_STANDBY_RELEASE && !st_ff.wait_busy;
    endsequence
    sequence s_wait_end;
        st_ff.wait_busy && interval_hit && !I_STANDBY_RELEASE;
    endsequence
    // restart too early in the watchdog window
    sequence s_early_restart;
        st_ff.wd_arm && restart_req && (st_ff.wd_cnt < WD_OPEN);
    endsequence

    AST_COUNT_STEP: assert property (pulse && !clr_req |=>
        st_ff.counter == $past(st_ff.counter) + CNT_ONE)
        else $error("counter did not advance on a count pulse");
    AST_SRC_TMR0: assert property ((st_ff.src == SRC_TMR0) |->
        (pulse == I_TMR0_COUNTUP))
        else $error("timer0 source not followed");
    AST_SRC_SLOW: assert property ((st_ff.src == SRC_DIV8192) && !tick.slow |-> !pulse)
        else $error("slow source counted without its tick");
    AST_ZC_PATH: assert property ((st_ff.src == SRC_PIN) && st_ff.zc_en |->
        (pulse == (st_ff.zc_s2 && !st_ff.zc_s3)))
        else $error("zero-cross path not used");
    AST_CLEAR: assert property (clr_req |=> st_ff.counter == '0)
        else $error("counter not cleared");
    AST_CLR_READS0: assert property (rd_mode_q |-> !O_HRDATA[MODE_CLR])
        else $error("clear bit read back as one");
    AST_INT32: assert property (st_ff.isel && pulse && !clr_req
        && (st_ff.counter[4:0] == CNT_LAST_32) |=> O_INTERVAL_EVT)
        else $error("32-pulse interval event missing");
    AST_INT128: assert property (!st_ff.isel && !clr_req && pulse
        && (st_ff.counter != CNT_LAST_128) |=> !O_INTERVAL_EVT)
        else $error("spurious 128-pulse interval event");
    AST_SEL_KEEP: assert property (wr_mode && !I_HWDATA[MODE_CLR] && !pulse |=>
        $stable(st_ff.counter))
        else $error("mode write disturbed the counter");
    AST_MODE_REG: assert property (wr_mode |=>
        st_ff.isel == $past(I_HWDATA[MODE_ISEL]) && st_ff.src == $past(I_HWDATA[1:0]))
        else $error("mode register not written");
    AST_RESTART: assert property (restart_req && st_ff.wd_arm |=>
        st_ff.wd_cnt == '0)
        else $error("watchdog restart did not rearm");
    AST_WAIT_START: assert property (s_release |=> st_ff.wait_busy)
        else $error("standby wait not started");
    AST_WAIT_DONE: assert property (s_wait_end |=> O_WAIT_DONE && !st_ff.wait_busy)
        else $error("standby wait did not end on interval");
    AST_WD_FIRE: assert property (st_ff.wd_arm && pulse && !clr_req && !restart_req
        && (st_ff.wd_cnt == WD_FIRE - WD_ONE) |=> O_WDT_RESET ##1 !O_WDT_RESET)
        else $error("watchdog reset not one cycle at 192");
    AST_WD_ARM: assert property (st_ff.wd_arm |=> st_ff.wd_arm)
        else $error("watchdog arm dropped");
    AST_COUNT_HOLD: assert property (!pulse && !clr_req |=> $stable(st_ff.counter))
        else $error("counter moved without a count pulse");
    AST_SRC_FAST: assert property ((st_ff.src == SRC_DIV4096) |->
        (pulse == tick.fast))
        else $error("fast source not followed");
    AST_PIN_PATH: assert property ((st_ff.src == SRC_PIN) && !st_ff.zc_en |->
        (pulse == (st_ff.pin_s2 && !st_ff.pin_s3)))
        else $error("event pin path not used");
    AST_INT128_HIT: assert property (!st_ff.isel && pulse && !clr_req
        && (st_ff.counter == CNT_LAST_128) |=> O_INTERVAL_EVT)
        else $error("128-pulse interval event missing");
    AST_EVT_ONE: assert property (O_INTERVAL_EVT |=> !O_INTERVAL_EVT)
        else $error("interval event longer than one cycle");
    AST_STAT_STICKY: assert property (st_ff.irq_stat[EV_INTERVAL]
        && !(st_ff.dp_write && (st_ff.dp_idx == IDX_STAT)) |=> st_ff.irq_stat[EV_INTERVAL])
        else $error("interval status bit lost without a clear");
    AST_RESTART_READS0: assert property (rd_wdog_q |-> !O_HRDATA[WDOG_RESTART])
        else $error("restart bit read back as one");
    AST_WD_STEP: assert property (st_ff.wd_arm && pulse && !clr_req && !restart_req
        && (st_ff.wd_cnt != WD_FIRE - WD_ONE) |=> st_ff.wd_cnt == $past(st_ff.wd_cnt) + WD_ONE)
        else $error("watchdog count did not advance");
    AST_WD_OFF: assert property (!st_ff.wd_arm && !clr_req && !restart_req |=>
        $stable(st_ff.wd_cnt) && !O_WDT_RESET)
        else $error("disarmed watchdog counted or fired");
    AST_EARLY: assert property (s_early_restart |=> O_WDT_RESET && st_ff.wd_cnt == '0)
        else $error("early restart did not fire the watchdog");
    AST_BUS_OKAY: assert property (O_HREADYOUT && !O_HRESP)
        else $error("bus stalled or answered with an error");
endmodule : basic_interval_timer
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    import bit_pkg::*;
    // ==========================================================
    // signals
    localparam int DS = 16;
    localparam int DF = 8;
    localparam logic [31:0] A_MODE = {25'h0, IDX_MODE, 2'h0};
    localparam logic [31:0] A_WDOG = {25'h0, IDX_WDOG, 2'h0};
    localparam logic [31:0] A_COUNT = {25'h0, IDX_COUNT, 2'h0};
    localparam logic [31:0] A_STAT = {25'h0, IDX_STAT, 2'h0};
    localparam logic [31:0] A_MASK = {25'h0, IDX_MASK, 2'h0};
    localparam logic [31:0] A_BAD = 32'h0000_0060;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic tmr0 = 1'b0;
    logic pin = 1'b0;
    logic zc = 1'b0;
    logic sby = 1'b0;
    logic evt;
    logic wdone;
    logic wdt;
    logic irq;
    logic [31:0] rd;
    int err_count = 0;
    int checks = 0;
    int evt_n = 0;
    int wait_n = 0;
    int wdt_n = 0;
    int base;
    int exp_n;

    always #20 clk = ~clk;

    basic_interval_timer #(.DIV_SLOW(DS), .DIV_FAST(DF)) basic_interval_timer_inst (
        .I_CLK_SYS(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_TMR0_COUNTUP(tmr0),
        .I_EVENT_PIN(pin), .I_ZERO_CROSS(zc), .I_STANDBY_RELEASE(sby), .O_INTERVAL_EVT(evt),
        .O_WAIT_DONE(wdone), .O_WDT_RESET(wdt), .O_IRQ(irq)
    );

    // ==========================================================
    // high cycles of the interval, wait-done and watchdog reset outputs
    always @(posedge clk) begin
        if (evt === 1'b1) evt_n <= evt_n + 1;
        if (wdone === 1'b1) wait_n <= wait_n + 1;
        if (wdt === 1'b1) wdt_n <= wdt_n + 1;
    end

    // ==========================================================
    // tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr

    task rd_chk(input logic [31:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask : rd_chk

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            tmr0 <= 1'b1;
            @(posedge clk);
            tmr0 <= 1'b0;
        end
        idle(3);
    endtask : pulse

    task edge_in(input logic use_zc);
        @(posedge clk);
        if (use_zc) zc <= 1'b1;
        else pin <= 1'b1;
        idle(6);
        zc <= 1'b0;
        pin <= 1'b0;
        idle(6);
    endtask : edge_in

    task note(input string name);
        $display("test %s done", name);
    endtask : note

    task results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // ==========================================================
    // hang guard
    initial begin
        #(10000 * 40);
        err_count++;
        results();
    end

    // ==========================================================
    // tests
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(A_MODE, 32'h0);
        rd_chk(A_WDOG, 32'h0);
        rd_chk(A_STAT, 32'h0);
        wr(A_BAD, 32'hFFFF_FFFF);
        rd_chk(A_BAD, 32'h0);
        check({31'h0, hresp}, 32'h0);
        note("reset");
        wr(A_MODE, 32'h6);
        rd_chk(A_MODE, 32'h2);
        rd_chk(A_COUNT, 32'h0);
        pulse(5);
        rd_chk(A_COUNT, 32'h5);
        wr(A_MODE, 32'hA);
        rd_chk(A_COUNT, 32'h5);
        base = evt_n;
        pulse(26);
        check(32'(evt_n - base), 32'h0);
        pulse(1);
        check(32'(evt_n - base), 32'h1);
        wr(A_MODE, 32'h6);
        base = evt_n;
        pulse(127);
        check(32'(evt_n - base), 32'h0);
        pulse(1);
        check(32'(evt_n - base), 32'h1);
        rd_chk(A_COUNT, 32'h0);
        note("interval");
        for (int s = 0; s < 2; s++) begin
            wr(A_MODE, 32'(4 + s));
            idle(160);
            bus(A_COUNT, 1'b0, 32'h0);
            exp_n = (s == 1) ? 160 / DF : 160 / DS;
            check({31'h0, rd >= exp_n - 1 && rd <= exp_n + 1}, 32'h1);
        end
        wr(A_MODE, 32'h7);
        repeat (3) edge_in(1'b0);
        rd_chk(A_COUNT, 32'h3);
        wr(A_WDOG, 32'h4);
        wr(A_MODE, 32'h7);
        repeat (2) edge_in(1'b1);
        edge_in(1'b0);
        rd_chk(A_COUNT, 32'h2);
        wr(A_WDOG, 32'h0);
        note("sources");
        wr(A_MODE, 32'hE);
        base = wait_n;
        @(posedge clk);
        sby <= 1'b1;
        @(posedge clk);
        sby <= 1'b0;
        pulse(31);
        check(32'(wait_n - base), 32'h0);
        pulse(1);
        check(32'(wait_n - base), 32'h1);
        note("standby");
        wr(A_MODE, 32'h6);
        wr(A_WDOG, 32'h2);
        base = wdt_n;
        pulse(10);
        wr(A_WDOG, 32'h3);
        rd_chk(A_WDOG, 32'h2);
        check(32'(wdt_n - base), 32'h0);
        wr(A_WDOG, 32'h0);
        pulse(3);
        wr(A_WDOG, 32'h1);
        idle(3);
        check(32'(wdt_n - base), 32'h1);
        pulse(191);
        check(32'(wdt_n - base), 32'h1);
        pulse(1);
        check(32'(wdt_n - base), 32'h2);
        note("watchdog");
        rd_chk(A_STAT, 32'h7);
        check({31'h0, irq}, 32'h0);
        wr(A_MASK, 32'h2);
        idle(2);
        check({31'h0, irq}, 32'h1);
        rd_chk(A_MASK, 32'h2);
        wr(A_STAT, 32'h2);
        idle(2);
        check({31'h0, irq}, 32'h0);
        wr(A_STAT, 32'h5);
        rd_chk(A_STAT, 32'h0);
        note("irq");
        results();
    end
endmodule : tb
`default_nettype wire
